// File: include/lsb_consts.vh
`ifndef LSB_CONSTS_VH
`define LSB_CONSTS_VH
// led colour codes
`define LSB_LED_NONE 2'h0
`define LSB_LED_RED 2'h1
`define LSB_LED_GREEN 2'h2
`define LSB_LED_BLUE 2'h3
// reset values
`define LSB_LED_RST 2'h0
`define LSB_IRQ_OE_N_RST 1'h1
// auto-initialization length
`define LSB_INIT_TIME_US 10
`define LSB_CLK_MHZ 100
`define LSB_INIT_CYCLES (`LSB_INIT_TIME_US * `LSB_CLK_MHZ)
// temperature conversion
`define LSB_ADC_BITS 8
`define LSB_RAMP_SETTLE_CYCLES 16
// i2c control port
`define LSB_I2C_ADDR 7'h1B
// init states
`define LSB_ST_RESET 2'h0
`define LSB_ST_INIT 2'h1
`define LSB_ST_RUN 2'h2
`endif

// File: rtl/lsb_sar_adc.v
`timescale 1ns/1ps
`default_nettype none
`include "lsb_consts.vh"
// successive-approximation converter using an rc ramp as the reference
module lsb_sar_adc #(
  parameter BITS = `LSB_ADC_BITS,
  parameter SETTLE = `LSB_RAMP_SETTLE_CYCLES
) (
  input wire clk,
  input wire rst,
  input wire start,
  input wire comparator_result_in,
  output reg ramp_charge_out,
  output reg [BITS-1:0] result_q,
  output reg done_q
);
  reg [BITS-1:0] trial_q; // current trial code
  reg [BITS-1:0] bit_q; // one-hot bit under test
  reg [BITS-1:0] pwm_q; // ramp pwm phase counter
  reg [15:0] settle_q; // settle counter per decision
  reg busy_q;
  // ramp level is a pwm of the trial code; the rc filter smooths it
  always @(posedge clk) begin
    if (rst) begin
      ramp_charge_out <= 1'b0;
      pwm_q <= {BITS{1'b0}};
    end else begin
      pwm_q <= pwm_q + 1'b1;
      ramp_charge_out <= busy_q && (pwm_q < trial_q);
    end
  end
  // one decision per bit, taken after the ramp has settled
  always @(posedge clk) begin
    if (rst) begin
      trial_q <= {BITS{1'b0}};
      bit_q <= {BITS{1'b0}};
      settle_q <= 16'h0000;
      busy_q <= 1'b0;
      result_q <= {BITS{1'b0}};
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (!busy_q) begin
        if (start) begin
          busy_q <= 1'b1;
          bit_q <= {1'b1, {(BITS-1){1'b0}}};
          trial_q <= {1'b1, {(BITS-1){1'b0}}};
          settle_q <= 16'h0000;
        end
      end else if (settle_q != SETTLE[15:0]) begin
        settle_q <= settle_q + 16'h0001;
      end else begin
        settle_q <= 16'h0000;
        // comparator high means the ramp is below the thermistor: keep the bit
        if (!comparator_result_in) begin
          trial_q <= (trial_q & ~bit_q) | (bit_q >> 1);
        end else begin
          trial_q <= trial_q | (bit_q >> 1);
        end
        bit_q <= bit_q >> 1;
        if (bit_q[0]) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
          result_q <= comparator_result_in ? trial_q : (trial_q & ~bit_q);
        end
      end
    end
  end
endmodule // lsb_sar_adc
`default_nettype wire

// File: rtl/lsb_sideband.v
// How it works
// - led select codes: 00 none,01 r,10 g,11 b
// - led select low during reset
// - led select low until auto-init completes
// - interrupt shows init progress and completion
// - interrupt floats while reset asserted
// - sar conversion: comparator decides, ramp pin drives
// - i2c target on port 0 for host
`timescale 1ns/1ps
`default_nettype none
`include "lsb_consts.vh"
module lsb_sideband #(
  parameter INIT_CYCLES = `LSB_INIT_CYCLES,
  parameter ADC_BITS = `LSB_ADC_BITS
) (
  input wire clk,
  input wire rst,
  input wire [1:0] seq_colour, // colour requested by the display sequencer
  input wire temp_start, // pulse: start a temperature conversion
  input wire comparator_result_in,
  output reg ramp_charge_out,
  output reg [ADC_BITS-1:0] temp_code_q,
  output reg temp_done_q,
  output reg [1:0] led_colour_select,
  output reg host_irq_out,
  output reg host_irq_oe_n, // low while driving
  output reg init_done_q,
  input wire control_i2c_clock_in,
  output reg control_i2c_clock_out,
  output reg control_i2c_clock_oe_n,
  input wire control_i2c_data_in,
  output reg control_i2c_data_out,
  output reg control_i2c_data_oe_n,
  output reg [7:0] i2c_rx_byte_q, // last byte written by the host
  output reg i2c_rx_valid_q // pulse per received byte
);
  // init sequencer states, binary coded
  localparam [1:0] ST_RESET = `LSB_ST_RESET; // first edge after reset release
  localparam [1:0] ST_INIT = `LSB_ST_INIT; // counting the init time
  localparam [1:0] ST_RUN = `LSB_ST_RUN; // init over, sequence in charge
  reg [1:0] st_q; // init state
  reg [31:0] cnt_q; // auto-init cycle counter
  wire ramp_w; // raw ramp from the converter
  wire [ADC_BITS-1:0] adc_res_w; // raw conversion result
  wire adc_done_w; // raw end-of-conversion pulse
  // auto-initialization sequencer; counts a fixed time after reset
  // a fixed count stands in for the real load work, so its length is a parameter
  always @(posedge clk) begin
    if (rst) begin
      st_q <= ST_RESET;
      cnt_q <= 32'h00000000;
      init_done_q <= 1'b0;
    end else begin
      case (st_q)
        // leave reset: start counting from zero
        ST_RESET: begin
          st_q <= ST_INIT;
          cnt_q <= 32'h00000000;
        end
        // count the init time, then hand over to the sequence
        ST_INIT: begin
          if (cnt_q >= INIT_CYCLES - 1) begin
            // last init cycle: done rises with the state change
            st_q <= ST_RUN;
            init_done_q <= 1'b1;
          end else begin
            // still initializing
            cnt_q <= cnt_q + 32'h00000001;
          end
        end
        // running: stays here until the next reset
        ST_RUN: begin
          init_done_q <= 1'b1;
        end
        // unused code: restart init rather than run uninitialized
        default: begin
          st_q <= ST_RESET;
        end
      endcase
    end
  end
  // led select: forced low in reset and through init
  // registered so the pins never glitch on a state change
  always @(posedge clk) begin
    if (rst) begin
      // reset: all leds off
      led_colour_select <= `LSB_LED_RST;
    end else if (st_q != ST_RUN) begin
      // init still running: leds off whatever the sequencer asks
      led_colour_select <= `LSB_LED_NONE;
    end else begin
      // sequence drives the colour code straight through
      led_colour_select <= seq_colour;
    end
  end
  // host interrupt: released in reset so the pull-up sets the level
  // high while initializing, low once done; the host waits for the low level
  always @(posedge clk) begin
    if (rst) begin
      // released; the value behind the enable is kept low
      host_irq_oe_n <= `LSB_IRQ_OE_N_RST;
      host_irq_out <= 1'b0;
    end else begin
      // driven from the first edge after reset
      host_irq_oe_n <= 1'b0;
      host_irq_out <= (st_q != ST_RUN);
    end
  end
  // temperature converter
  lsb_sar_adc #(
    .BITS(ADC_BITS),
    .SETTLE(`LSB_RAMP_SETTLE_CYCLES)
  ) u_adc (
    .clk(clk),
    .rst(rst),
    .start(temp_start && init_done_q),
    .comparator_result_in(comparator_result_in),
    .ramp_charge_out(ramp_w),
    .result_q(adc_res_w),
    .done_q(adc_done_w)
  );
  // register converter outputs so top outputs stay flop-driven
  // costs one cycle of lag on the ramp pin, which the rc filter swamps anyway
  always @(posedge clk) begin
    if (rst) begin
      ramp_charge_out <= 1'b0;
      temp_code_q <= {ADC_BITS{1'b0}};
      temp_done_q <= 1'b0;
    end else begin
      ramp_charge_out <= ramp_w;
      temp_done_q <= adc_done_w;
      // keep the last result until the next conversion ends
      if (adc_done_w) begin
        temp_code_q <= adc_res_w;
      end
    end
  end
  // i2c target, write-only; simple since the host is the only controller
  // limitation: reads are refused (no ack), so the host cannot poll status here
  reg scl1_q, sda1_q; // edge history
  reg [3:0] bit_cnt_q; // bits shifted in this byte
  reg [7:0] sh_q; // receive shift register
  reg addr_ph_q; // first byte is the address
  reg active_q; // addressed to us
  reg ack_q; // driving ack this bit
  // edges and bus conditions, judged against the previous sample
  wire scl_rise = control_i2c_clock_in && !scl1_q;
  wire scl_fall = !control_i2c_clock_in && scl1_q;
  wire start_c = scl1_q && control_i2c_clock_in && sda1_q && !control_i2c_data_in;
  wire stop_c = scl1_q && control_i2c_clock_in && !sda1_q && control_i2c_data_in;
  // history resets to the idle-high level so no false edge follows reset
  always @(posedge clk) begin
    if (rst) begin
      scl1_q <= 1'b1;
      sda1_q <= 1'b1;
      bit_cnt_q <= 4'h0;
      sh_q <= 8'h00;
      addr_ph_q <= 1'b0;
      active_q <= 1'b0;
      ack_q <= 1'b0;
      i2c_rx_byte_q <= 8'h00;
      i2c_rx_valid_q <= 1'b0;
      control_i2c_clock_out <= 1'b0;
      control_i2c_clock_oe_n <= 1'b1; // never stretch the clock
      control_i2c_data_out <= 1'b0;
      control_i2c_data_oe_n <= 1'b1;
    end else begin
      // pin history for edge detection
      scl1_q <= control_i2c_clock_in;
      sda1_q <= control_i2c_data_in;
      // receive pulse lasts one cycle
      i2c_rx_valid_q <= 1'b0;
      if (start_c) begin
        // start or repeated start: expect an address byte
        bit_cnt_q <= 4'h0;
        addr_ph_q <= 1'b1;
        active_q <= 1'b0;
        ack_q <= 1'b0;
        control_i2c_data_oe_n <= 1'b1;
      end else if (stop_c) begin
        // stop: drop the selection and release the data line
        addr_ph_q <= 1'b0;
        active_q <= 1'b0;
        ack_q <= 1'b0;
        control_i2c_data_oe_n <= 1'b1;
      end else if (scl_rise && !ack_q && (addr_ph_q || active_q)) begin
        // data is stable while the clock is high: shift it in
        sh_q <= {sh_q[6:0], control_i2c_data_in};
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end else if (scl_fall) begin
        // the data line is only changed while the clock is low
        if (ack_q) begin
          // ack clock over: release and start the next byte
          ack_q <= 1'b0;
          control_i2c_data_oe_n <= 1'b1; // release after ack
          bit_cnt_q <= 4'h0;
        end else if (bit_cnt_q == 4'h8) begin
          // a whole byte is in
          if (addr_ph_q) begin
            addr_ph_q <= 1'b0;
            // ack only our own address with the write bit
            if (sh_q[7:1] == `LSB_I2C_ADDR && !sh_q[0]) begin
              active_q <= 1'b1;
              ack_q <= 1'b1;
              control_i2c_data_oe_n <= 1'b0;
            end
          end else if (active_q) begin
            // data byte for us: hand it over and ack it
            i2c_rx_byte_q <= sh_q;
            i2c_rx_valid_q <= 1'b1;
            ack_q <= 1'b1;
            control_i2c_data_oe_n <= 1'b0;
          end
        end
      end
    end
  end
endmodule // lsb_sideband
`default_nettype wire

// File: testbench/lsb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host: i2c controller on pulled-up lines, interrupt line with pull-up
module lsb_host_model (
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  input wire logic irq_oe_n,
  input wire logic irq_out,
  output logic scl,
  output logic sda,
  output logic irq_line
);
  logic scl_h = 1'b1; // host only pulls low
  logic sda_h = 1'b1;
  // open drain: a released line reads the pull-up level
  assign scl = scl_h & scl_oe_n;
  assign sda = sda_h & sda_oe_n;
  assign irq_line = irq_oe_n ? 1'b1 : irq_out;
  // one byte msb first, ack sampled on the ninth high clock
  task automatic xfer(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #100 sda_h = b[i];
      #100 scl_h = 1'b1;
      #200 scl_h = 1'b0;
    end
    #100 sda_h = 1'b1;
    #100 scl_h = 1'b1;
    ack = !sda;
    #200 scl_h = 1'b0;
  endtask
  // start, address, optional data byte, stop
  task automatic frame(input logic [7:0] adr, input logic [7:0] dat, output logic [1:0] acks);
    acks = 2'h0;
    sda_h = 1'b0;
    #200 scl_h = 1'b0;
    xfer(adr, acks[1]);
    if (!adr[0]) xfer(dat, acks[0]);
    #100 sda_h = 1'b0;
    #100 scl_h = 1'b1;
    #100 sda_h = 1'b1;
  endtask
endmodule // lsb_host_model
`default_nettype wire

// File: testbench/lsb_sideband_chk.sv
`timescale 1ns/1ps
`default_nettype none
// watches reset, init and colour behaviour at the sideband ports
module lsb_sideband_chk #(
  parameter int INIT_CYCLES = 1000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] seq_colour,
  input wire logic [1:0] led_colour_select,
  input wire logic host_irq_out,
  input wire logic host_irq_oe_n,
  input wire logic init_done_q,
  input wire logic temp_done_q
);
  logic [15:0] age_q; // edges since reset release
  // counter lets the init length be judged without a long repetition
  always_ff @(posedge clk) age_q <= rst ? 16'h0 : age_q + 16'h1;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_done; $rose(init_done_q); endsequence
  sequence s_irq_low; !host_irq_oe_n && !host_irq_out; endsequence
  chk_led_reset: assert property (disable iff (1'b0) rst |=> led_colour_select == 2'h0)
    else $error("led on in reset");
  chk_irq_float: assert property (disable iff (1'b0) rst |=> host_irq_oe_n)
    else $error("irq driven in reset");
  chk_led_init: assert property (!init_done_q |-> led_colour_select == 2'h0)
    else $error("led on during init");
  chk_led_follow: assert property (init_done_q |=> led_colour_select == $past(seq_colour))
    else $error("led not following sequence");
  chk_irq_busy: assert property (!init_done_q && !$past(rst) |-> !host_irq_oe_n && host_irq_out)
    else $error("irq not high during init");
  chk_irq_done: assert property (s_done |=> s_irq_low[*3])
    else $error("irq not low after init");
  chk_init_len: assert property (s_done |-> age_q >= INIT_CYCLES - 1 && age_q <= INIT_CYCLES + 3)
    else $error("init length wrong");
  chk_temp_early: assert property (!init_done_q |-> !temp_done_q)
    else $error("conversion before init");
endmodule // lsb_sideband_chk
bind lsb_sideband lsb_sideband_chk #(.INIT_CYCLES(INIT_CYCLES)) chk_u (.clk, .rst, .seq_colour,
  .led_colour_select, .host_irq_out, .host_irq_oe_n, .init_done_q, .temp_done_q);
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] seq_colour = 2'h3; // blue asked for during init
  logic temp_start = 1'b0;
  logic comparator_result_in = 1'b0;
  wire logic ramp_charge_out, temp_done_q, host_irq_out, host_irq_oe_n, init_done_q, i2c_rx_valid_q;
  wire logic [7:0] temp_code_q, i2c_rx_byte_q;
  wire logic [1:0] led_colour_select;
  wire logic scl, sda, irq_line, control_i2c_clock_oe_n, control_i2c_data_oe_n;
  wire logic scl_drv, sda_drv; // level driven when a pin is enabled
  int fail_count = 0;
  int total_checks = 0;
  logic [7:0] rx_seen = 8'h00; // last byte handed over
  logic done_seen = 1'b0; // a conversion finished
  logic ramp_seen = 1'b0; // ramp pin went high
  always #5 clk = ~clk;
  // short init count keeps the run brief
  lsb_sideband #(.INIT_CYCLES(20)) dut_u (.clk, .rst, .seq_colour, .temp_start,
    .comparator_result_in, .ramp_charge_out, .temp_code_q, .temp_done_q, .led_colour_select,
    .host_irq_out, .host_irq_oe_n, .init_done_q, .control_i2c_clock_in(scl),
    .control_i2c_clock_out(scl_drv), .control_i2c_clock_oe_n, .control_i2c_data_in(sda),
    .control_i2c_data_out(sda_drv), .control_i2c_data_oe_n, .i2c_rx_byte_q, .i2c_rx_valid_q);
  lsb_host_model host_u (.scl_oe_n(control_i2c_clock_oe_n), .sda_oe_n(control_i2c_data_oe_n),
    .irq_oe_n(host_irq_oe_n), .irq_out(host_irq_out), .scl, .sda, .irq_line);
  // catch one-cycle pulses
  always @(posedge clk) begin
    if (i2c_rx_valid_q === 1'b1) rx_seen <= i2c_rx_byte_q;
    if (temp_done_q === 1'b1) done_seen <= 1'b1;
    if (ramp_charge_out === 1'b1) ramp_seen <= 1'b1;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic do_reset;
    @(negedge clk) rst = 1'b1;
    repeat (8) @(negedge clk);
    chk("led in reset", 8'h00, led_colour_select);
    chk("irq in reset", 8'h01, irq_line);
    chk("irq released", 8'h01, host_irq_oe_n);
    rst = 1'b0;
  endtask
  // start request during init must be ignored
  task automatic t_init;
    int n;
    n = 0;
    done_seen = 1'b0;
    temp_start = 1'b1;
    @(negedge clk) temp_start = 1'b0;
    while (init_done_q !== 1'b1 && n < 100) begin
      chk("led in init", 8'h00, led_colour_select);
      chk("irq in init", 8'h01, irq_line);
      chk("irq driven", 8'h00, host_irq_oe_n);
      chk("ramp idle", 8'h00, ramp_charge_out);
      @(negedge clk);
      n++;
    end
    chk("init length", 8'h01, n >= 19 && n <= 23);
    repeat (2) @(negedge clk);
    chk("irq after init", 8'h00, irq_line);
    chk("early start", 8'h00, done_seen);
  endtask
  task automatic t_colours;
    for (int c = 0; c < 4; c++) begin
      seq_colour = c[1:0];
      repeat (2) @(negedge clk);
      chk("led colour", c[7:0], led_colour_select);
    end
  endtask
  task automatic t_temp(input logic level, input logic [7:0] exp);
    int n;
    n = 0;
    comparator_result_in = level;
    done_seen = 1'b0;
    ramp_seen = 1'b0;
    temp_start = 1'b1;
    @(negedge clk) temp_start = 1'b0;
    while (done_seen !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk("conversion time", 8'h01, n >= 130 && n <= 170);
    chk("temp code", exp, temp_code_q);
    if (level) chk("ramp active", 8'h01, ramp_seen);
    chk("ramp after", 8'h00, ramp_charge_out);
  endtask
  task automatic t_i2c;
    logic [1:0] a;
    host_u.frame(8'h36, 8'hA5, a);
    chk("write acks", 8'h03, a);
    chk("rx byte", 8'hA5, rx_seen);
    host_u.frame(8'h37, 8'h00, a);
    chk("read refused", 8'h00, a);
    chk("scl never held", 8'h01, control_i2c_clock_oe_n);
    chk("pull levels", 8'h00, {scl_drv, sda_drv});
  endtask
  initial begin
    do_reset;
    t_init;
    t_colours;
    t_temp(1'b1, 8'hFF);
    t_temp(1'b0, 8'h00);
    t_i2c;
    do_reset;
    t_init;
    end_sim;
  end
  initial begin
    #300000;
    fail_count++;
    end_sim;
  end
endmodule // testbench
`default_nettype wire
